/* ppfm_consts.svh */
// register offsets, reset values and field positions of the port pin mux
// assumes an 8-bit special-function register space with 16-bit addresses
// How it works
// - each pwm port bit is set to input or output by software
// - reset forces every programmable port bit to input
// - reset pin is an input and driven low by internal reset sources
// - all port and control registers sit in the special-function space
`ifndef PPFM_CONSTS_SVH
`define PPFM_CONSTS_SVH
`define PPFM_ADDR_P2         16'h0002
`define PPFM_ADDR_P3         16'h0003
`define PPFM_ADDR_P4         16'h0004
`define PPFM_ADDR_P5         16'h0005
`define PPFM_ADDR_P6         16'h0006
`define PPFM_ADDR_P7         16'h0007
`define PPFM_ADDR_P4_DIR     16'h000c
`define PPFM_ADDR_P6_DIR     16'h000e
`define PPFM_ADDR_VSEL       16'h0f91
`define PPFM_LATCH_RST       8'hff
`define PPFM_DIR_RST         8'h00
`define PPFM_VSEL_RST        8'h00
`define PPFM_VSEL_LSB        4
`define PPFM_SYNC_W          34
`endif

/* ppfm_pkg.sv */
// types shared by the port pin mux files
// assumes ppfm_consts.svh supplies the numeric constants
package ppfm_pkg;
   typedef logic [7:0]  ppfm_byte_t;
   typedef logic [15:0] ppfm_addr_t;
endpackage : ppfm_pkg

/* ppfm_sync.sv */
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clock; ce freezes the chain
`timescale 1ns/1ps
module ppfm_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // data
   input  wire logic [W-1:0] d_async,
   output logic      [W-1:0] q_sync
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   always_comb
   begin
      meta_next = ce ? d_async : meta_reg;
      q_next    = ce ? meta_reg : q_sync;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '1;
         q_sync   <= '1;
      end
      else
      begin
         meta_reg <= meta_next;
         q_sync   <= q_next;
      end
   end
endmodule : ppfm_sync

/* ppfm_top.sv */
// port latches, direction registers and alternate-function pin mux
// assumes a same-clock register port from the core and asynchronous pins
`timescale 1ns/1ps
`include "ppfm_consts.svh"
module ppfm_top (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // special-function register port
   input  wire ppfm_pkg::ppfm_addr_t sfr_addr,
   input  wire logic              sfr_wr,
   input  wire logic              sfr_rd,
   input  wire ppfm_pkg::ppfm_byte_t sfr_wdata,
   output ppfm_pkg::ppfm_byte_t   sfr_rdata,
   // alternate outputs from peripherals
   input  wire logic [7:1]        pwm_out_7bit,
   input  wire logic              pwm_out_14bit,
   input  wire logic [5:0]        p3_alt_out,
   input  wire logic [7:0]        p5_alt_out,
   input  wire logic [2:0]        osd_rgb,
   input  wire logic              focus_blank_out,
   // internal reset sources
   input  wire logic              wdt_rst,
   input  wire logic              trap_rst,
   input  wire logic              clk_rst,
   // pins
   input  wire logic              p2_in,
   output logic                   p2_out,
   output logic                   p2_oe,
   input  wire logic [5:0]        p3_in,
   output logic      [5:0]        p3_out,
   output logic      [5:0]        p3_oe,
   input  wire logic [7:0]        p4_in,
   output logic      [7:0]        p4_out,
   output logic      [7:0]        p4_oe,
   input  wire logic [7:0]        p5_in,
   output logic      [7:0]        p5_out,
   output logic      [7:0]        p5_oe,
   input  wire logic [7:0]        p6_in,
   output logic      [7:0]        p6_out,
   output logic      [7:0]        p6_oe,
   input  wire logic [1:0]        p7_in,
   output logic      [1:0]        p7_out,
   output logic      [1:0]        p7_oe,
   input  wire logic              rst_pin_in,
   output logic                   rst_pin_out,
   output logic                   rst_pin_oe,
   // synchronised inputs to peripherals
   output logic                   ext_reset_req,
   output logic                   timer3_in,
   output logic                   ext_irq_4,
   output logic                   remote_preproc_in,
   output logic                   vert_sync_in,
   output logic                   horiz_sync_in
);
   import ppfm_pkg::*;

   // register state
   logic      p2_reg, p2_next;
   logic [5:0] p3_reg, p3_next;
   ppfm_byte_t p4_reg, p4_next, p4_dir_reg, p4_dir_next;
   ppfm_byte_t p5_reg, p5_next;
   ppfm_byte_t p6_reg, p6_next, p6_dir_reg, p6_dir_next;
   logic [1:0] p7_reg, p7_next;
   ppfm_byte_t vsel_reg, vsel_next;
   ppfm_byte_t rdata_next;

   // synchronised pins
   logic [`PPFM_SYNC_W-1:0] pin_sync;
   logic       s_p2;
   logic [5:0] s_p3;
   ppfm_byte_t s_p4, s_p5, s_p6;
   logic [1:0] s_p7;
   logic       s_rst;

   ppfm_sync #(.W(`PPFM_SYNC_W)) u_sync (
      .clock   (clock),
      .rst_n   (rst_n),
      .ce      (ce),
      .d_async ({rst_pin_in, p7_in, p6_in, p5_in, p4_in, p3_in, p2_in}),
      .q_sync  (pin_sync)
   );
   assign {s_rst, s_p7, s_p6, s_p5, s_p4, s_p3, s_p2} = pin_sync;

   // register writes and reads; every address is an ordinary data access
   always_comb
   begin
      p2_next     = p2_reg;
      p3_next     = p3_reg;
      p4_next     = p4_reg;
      p4_dir_next = p4_dir_reg;
      p5_next     = p5_reg;
      p6_next     = p6_reg;
      p6_dir_next = p6_dir_reg;
      p7_next     = p7_reg;
      vsel_next   = vsel_reg;
      rdata_next  = sfr_rdata;
      if (ce && sfr_wr)
      begin
         case (sfr_addr)
            `PPFM_ADDR_P2:     p2_next     = sfr_wdata[0];
            `PPFM_ADDR_P3:     p3_next     = sfr_wdata[5:0];
            `PPFM_ADDR_P4:     p4_next     = sfr_wdata;
            `PPFM_ADDR_P4_DIR: p4_dir_next = sfr_wdata;
            `PPFM_ADDR_P5:     p5_next     = sfr_wdata;
            `PPFM_ADDR_P6:     p6_next     = sfr_wdata;
            `PPFM_ADDR_P6_DIR: p6_dir_next = sfr_wdata;
            `PPFM_ADDR_P7:     p7_next     = sfr_wdata[1:0];
            `PPFM_ADDR_VSEL:   vsel_next   = sfr_wdata;
            default:           p2_next     = p2_reg;
         endcase
      end
      if (ce && sfr_rd)
      begin
         // on ports 4 and 6 input bits read the pin, output bits read back their latch; ports 2, 3, 5 and 7 read the pins
         case (sfr_addr)
            `PPFM_ADDR_P2:     rdata_next = {7'h00, s_p2};
            `PPFM_ADDR_P3:     rdata_next = {2'h0, s_p3};
            `PPFM_ADDR_P4:     rdata_next = (p4_dir_reg & p4_reg) | (~p4_dir_reg & s_p4);
            `PPFM_ADDR_P4_DIR: rdata_next = p4_dir_reg;
            `PPFM_ADDR_P5:     rdata_next = s_p5;
            `PPFM_ADDR_P6:     rdata_next = (p6_dir_reg & p6_reg) | (~p6_dir_reg & s_p6);
            `PPFM_ADDR_P6_DIR: rdata_next = p6_dir_reg;
            `PPFM_ADDR_P7:     rdata_next = {6'h00, s_p7};
            `PPFM_ADDR_VSEL:   rdata_next = vsel_reg;
            default:           rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p2_reg     <= 1'b1;
         p3_reg     <= 6'h3f;
         p4_reg     <= `PPFM_LATCH_RST;
         p4_dir_reg <= `PPFM_DIR_RST;
         p5_reg     <= `PPFM_LATCH_RST;
         p6_reg     <= `PPFM_LATCH_RST;
         p6_dir_reg <= `PPFM_DIR_RST;
         p7_reg     <= 2'h3;
         vsel_reg   <= `PPFM_VSEL_RST;
         sfr_rdata  <= 8'h00;
      end
      else
      begin
         p2_reg     <= p2_next;
         p3_reg     <= p3_next;
         p4_reg     <= p4_next;
         p4_dir_reg <= p4_dir_next;
         p5_reg     <= p5_next;
         p6_reg     <= p6_next;
         p6_dir_reg <= p6_dir_next;
         p7_reg     <= p7_next;
         vsel_reg   <= vsel_next;
         sfr_rdata  <= rdata_next;
      end
   end

   // pin drivers, registered so every output comes from a flip-flop
   logic       p2_out_next, p2_oe_next, rst_oe_next;
   logic [5:0] p3_out_next, p3_oe_next;
   ppfm_byte_t p4_out_next, p5_out_next, p5_oe_next, p6_out_next, p6_oe_next;
   logic [1:0] p7_out_next, p7_oe_next;
   logic [5:0] peri_next, peri_reg;
   logic [3:0] video_alt;

   always_comb
   begin
      // latch ports are wired-and: a low latch pulls the pin low, a high
      // latch lets the alternate function through, hence the set-to-one need
      p2_out_next = p2_reg;
      p2_oe_next  = ~p2_reg;
      p3_out_next = p3_reg & p3_alt_out;
      p3_oe_next  = ~p3_out_next;
      p5_out_next = p5_reg & p5_alt_out;
      p5_oe_next  = ~p5_out_next;
      p7_out_next = p7_reg;
      p7_oe_next  = ~p7_reg;
      // pwm is gated by the latch, so a cleared latch silences the channel
      p4_out_next = p4_reg & {pwm_out_7bit, pwm_out_14bit};
      // upper video pins carry display colours when selected, else the latch
      p6_out_next = p6_reg;
      p6_oe_next  = p6_dir_reg;
      // bit 7 blanking, bits 6..4 blue, green, red
      video_alt   = {focus_blank_out, osd_rgb};
      for (int i = 0; i < 4; i++)
      begin
         if (vsel_reg[`PPFM_VSEL_LSB + i])
         begin
            p6_out_next[`PPFM_VSEL_LSB + i] = video_alt[i];
            p6_oe_next[`PPFM_VSEL_LSB + i]  = 1'b1;
         end
      end
      // pin driven low by any internal reset source
      rst_oe_next = wdt_rst | trap_rst | clk_rst;
      peri_next   = {~s_rst, s_p3[1], s_p3[2], s_p3[0], s_p7[1], s_p7[0]};
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p2_out     <= 1'b1;
         p2_oe      <= 1'b0;
         p3_out     <= 6'h3f;
         p3_oe      <= 6'h00;
         p4_out     <= 8'h00;
         p4_oe      <= 8'h00;
         p5_out     <= 8'hff;
         p5_oe      <= 8'h00;
         p6_out     <= 8'h00;
         p6_oe      <= 8'h00;
         p7_out     <= 2'h3;
         p7_oe      <= 2'h0;
         rst_pin_oe <= 1'b0;
         rst_pin_out <= 1'b0;
         peri_reg   <= 6'h1f;
      end
      else if (ce)
      begin
         p2_out     <= p2_out_next;
         p2_oe      <= p2_oe_next;
         p3_out     <= p3_out_next;
         p3_oe      <= p3_oe_next;
         p4_out     <= p4_out_next;
         p4_oe      <= p4_dir_reg;
         p5_out     <= p5_out_next;
         p5_oe      <= p5_oe_next;
         p6_out     <= p6_out_next;
         p6_oe      <= p6_oe_next;
         p7_out     <= p7_out_next;
         p7_oe      <= p7_oe_next;
         rst_pin_oe <= rst_oe_next;
         // open drain: the reset pin only ever pulls low
         rst_pin_out <= 1'b0;
         peri_reg   <= peri_next;
      end
   end

   assign {ext_reset_req, timer3_in, ext_irq_4, remote_preproc_in,
           vert_sync_in, horiz_sync_in} = peri_reg;

   AST_DIR_RESET: assert property (@(posedge clock) !rst_n |=> p4_dir_reg == 8'h00)
      else $error("port 4 direction not input after reset");
   AST_P4_OE: assert property (@(posedge clock) disable iff (!rst_n)
      ce |=> p4_oe == $past(p4_dir_reg))
      else $error("port 4 enable does not follow direction");
   AST_DIR_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
      ce && sfr_wr && sfr_addr == `PPFM_ADDR_P4_DIR |=> p4_dir_reg == $past(sfr_wdata))
      else $error("direction write lost");
   AST_P4_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
      ce && p4_dir_reg[1] && pwm_out_7bit[1] |=> p4_out[1] == $past(p4_reg[1]))
      else $error("port 4 output does not show latch");
   AST_P6_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
      ce && !vsel_reg[4] && p6_dir_reg[4] |=> p6_oe[4] && p6_out[4] == $past(p6_reg[4]))
      else $error("port 6 output does not show latch");
   AST_RST_OUT: assert property (@(posedge clock) disable iff (!rst_n)
      ce && (wdt_rst || trap_rst || clk_rst) |=> rst_pin_oe && !rst_pin_out)
      else $error("reset pin not driven on internal reset");
   AST_RST_IN: assert property (@(posedge clock) disable iff (!rst_n)
      ce [*3] ##0 !rst_pin_in ##1 ce [*3] |-> ext_reset_req)
      else $error("external reset not seen");
   AST_VSEL_READ: assert property (@(posedge clock) disable iff (!rst_n)
      ce && sfr_rd && sfr_addr == `PPFM_ADDR_VSEL |=> sfr_rdata == $past(vsel_reg))
      else $error("select register readback wrong");
   AST_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n)
      ce && sfr_rd && sfr_addr == 16'h0100 |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");

   COV_P4_OUT: cover property (@(posedge clock) disable iff (!rst_n) p4_oe == 8'hff);
   COV_OSD: cover property (@(posedge clock) disable iff (!rst_n) vsel_reg[7:4] == 4'hf);
   COV_RST: cover property (@(posedge clock) disable iff (!rst_n) rst_pin_oe);
endmodule : ppfm_top

/* ppfm_board.sv */
// board-side model of the circuitry on every port pin
// assumes pins packed {rst, p7, p6, p5, p4, p3, p2}; ext_lvl is what the board
// drives where the device lets go (pull-ups read as 1)
`timescale 1ns/1ps
module ppfm_board (
   // device side
   input  wire logic [33:0] drv_out,
   input  wire logic [33:0] drv_oe,
   // board side
   input  wire logic [33:0] ext_lvl,
   output logic      [33:0] pin_in
);
   // device drive wins where enabled; open-drain ports only enable for a 0
   assign pin_in = (drv_oe & drv_out) | (~drv_oe & ext_lvl);
endmodule : ppfm_board

/* port_pin_function_mux_tb.sv */
// self-checking bench for the port pin mux
// assumes ppfm_top with ce held high and the board model on its pins
`timescale 1ns/1ps
`include "ppfm_consts.svh"
module port_pin_function_mux_tb;
   import ppfm_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   ppfm_addr_t sfr_addr = '0;
   ppfm_byte_t sfr_wdata = '0;
   ppfm_byte_t sfr_rdata;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, pwm14 = 1'b1, fbo = 1'b0, wdt = 1'b0;
   logic trap = 1'b0, clkr = 1'b0;
   logic [7:1] pwm_out_7bit_ch7 = 7'h7f;
   logic [5:0] p3a = 6'h3f;
   logic [7:0] p5a = 8'hff;
   logic [2:0] osd = 3'h0;
   logic [33:0] ext_lvl = '1;
   logic [33:0] pin_in, drv_out, drv_oe;
   logic p2_in, p2_out, p2_oe, rst_pin_in, rst_pin_out, rst_pin_oe;
   logic [5:0] p3_in, p3_out, p3_oe;
   logic [7:0] p4_in, p4_out, p4_oe, p5_in, p5_out, p5_oe, p6_in, p6_out, p6_oe;
   logic [1:0] p7_in, p7_out, p7_oe;
   logic ext_reset_req, timer3_in, ext_irq_4, remote_preproc_in, vsync, hsync;
   int fails = 0;
   int comparisons = 0;
   assign drv_out = {rst_pin_out, p7_out, p6_out, p5_out, p4_out, p3_out, p2_out};
   assign drv_oe  = {rst_pin_oe, p7_oe, p6_oe, p5_oe, p4_oe, p3_oe, p2_oe};
   assign {rst_pin_in, p7_in, p6_in, p5_in, p4_in, p3_in, p2_in} = pin_in;
   always #20 clock = ~clock;
   ppfm_board u_ppfm_board (.drv_out(drv_out), .drv_oe(drv_oe), .ext_lvl(ext_lvl),
      .pin_in(pin_in));
   ppfm_top u_ppfm_top (.clock(clock), .rst_n(rst_n), .ce(1'b1), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .pwm_out_7bit(pwm_out_7bit_ch7), .pwm_out_14bit(pwm14), .p3_alt_out(p3a), .p5_alt_out(p5a),
      .osd_rgb(osd), .focus_blank_out(fbo), .wdt_rst(wdt), .trap_rst(trap),
      .clk_rst(clkr), .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p3_in(p3_in),
      .p3_out(p3_out), .p3_oe(p3_oe), .p4_in(p4_in), .p4_out(p4_out), .p4_oe(p4_oe),
      .p5_in(p5_in), .p5_out(p5_out), .p5_oe(p5_oe), .p6_in(p6_in), .p6_out(p6_out),
      .p6_oe(p6_oe), .p7_in(p7_in), .p7_out(p7_out), .p7_oe(p7_oe),
      .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
      .ext_reset_req(ext_reset_req), .timer3_in(timer3_in), .ext_irq_4(ext_irq_4),
      .remote_preproc_in(remote_preproc_in), .vert_sync_in(vsync),
      .horiz_sync_in(hsync));

   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // strobes rise after a falling edge and are held across the sampling edge
   task wr(input ppfm_addr_t a, input ppfm_byte_t d);
      @(negedge clock);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clock);
      sfr_wr = 1'b0;
      // pins follow two edges after the write
      repeat (2) @(negedge clock);
   endtask : wr

   task rd(input ppfm_addr_t a, input ppfm_byte_t exp, input string nm);
      @(negedge clock);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clock);
      sfr_rd = 1'b0;
      chk(nm, exp, sfr_rdata);
   endtask : rd

   task t_reset;
      chk("p4_oe", 8'h00, p4_oe);
      chk("p6_oe", 8'h00, p6_oe);
      rd(`PPFM_ADDR_VSEL, 8'h00, "vsel");
      rd(16'h0100, 8'h00, "unmapped");
      $display("test reset done");
   endtask : t_reset

   task t_port4;
      ext_lvl[14:7] = 8'h81;
      wr(`PPFM_ADDR_P4_DIR, 8'h5a);
      wr(`PPFM_ADDR_P4, 8'h3c);
      chk("p4_oe", 8'h5a, p4_oe);
      chk("p4_out", 8'h18, p4_out & 8'h5a);
      wr(`PPFM_ADDR_P4, 8'hff);
      pwm_out_7bit_ch7 = 7'h55;
      pwm14 = 1'b0;
      repeat (3) @(negedge clock);
      chk("p4_pwm", 8'h0a, p4_out & 8'h5a);
      // output bits read the latch, input bits the pins
      rd(`PPFM_ADDR_P4, 8'hdb, "p4_read");
      $display("test port4 done");
   endtask : t_port4

   task t_video;
      osd = 3'h5;
      fbo = 1'b1;
      wr(`PPFM_ADDR_VSEL, 8'hf0);
      chk("p6_oe", 8'hf0, p6_oe & 8'hf0);
      chk("p6_out", 8'hd0, p6_out & 8'hf0);
      rd(`PPFM_ADDR_VSEL, 8'hf0, "vsel");
      $display("test video done");
   endtask : t_video

   task t_inputs;
      wr(`PPFM_ADDR_P3, 8'hff);
      wr(`PPFM_ADDR_P7, 8'hff);
      wr(`PPFM_ADDR_P5, 8'hff);
      ext_lvl[3:1] = 3'b010;
      ext_lvl[32:31] = 2'b01;
      p5a = 8'hf0;
      repeat (5) @(negedge clock);
      chk("sync_ins", 8'h09, {3'h0, ext_irq_4, timer3_in, remote_preproc_in, vsync,
         hsync});
      chk("p5_oe", 8'h0f, p5_oe);
      chk("p5_out", 8'hf0, p5_out);
      chk("p3_oe", 8'h00, {2'h0, p3_oe});
      chk("p3_out", 8'h3f, {2'h0, p3_out});
      $display("test inputs done");
   endtask : t_inputs

   // plain latch outputs, port 6 direction and readback of every port but the port 4 latch
   task t_ports;
      ext_lvl[32:31] = 2'b11;
      wr(`PPFM_ADDR_P2, 8'h00);
      wr(`PPFM_ADDR_P6_DIR, 8'h1f);
      wr(`PPFM_ADDR_VSEL, 8'he0);
      wr(`PPFM_ADDR_P6, 8'h05);
      wr(`PPFM_ADDR_P7, 8'h02);
      chk("p2_drive", 8'h02, {6'h00, p2_oe, p2_out});
      chk("p6_oe", 8'hff, p6_oe);
      chk("p6_out", 8'hc5, p6_out);
      chk("p7_oe", 8'h01, {6'h00, p7_oe});
      chk("p7_out", 8'h02, {6'h00, p7_out});
      rd(`PPFM_ADDR_P2, 8'h00, "p2_read");
      rd(`PPFM_ADDR_P3, 8'h3a, "p3_read");
      rd(`PPFM_ADDR_P4_DIR, 8'h5a, "p4_dir_read");
      rd(`PPFM_ADDR_P5, 8'hf0, "p5_read");
      rd(`PPFM_ADDR_P6, 8'hc5, "p6_read");
      rd(`PPFM_ADDR_P6_DIR, 8'h1f, "p6_dir_read");
      rd(`PPFM_ADDR_P7, 8'h02, "p7_read");
      $display("test ports done");
   endtask : t_ports

   task t_rstpin;
      ext_lvl[33] = 1'b0;
      repeat (5) @(negedge clock);
      chk("ext_reset_req", 8'h01, {7'h0, ext_reset_req});
      ext_lvl[33] = 1'b1;
      wdt = 1'b1;
      repeat (3) @(negedge clock);
      chk("rst_pin_oe", 8'h01, {7'h0, rst_pin_oe});
      chk("rst_pin_out", 8'h00, {7'h0, rst_pin_out});
      wdt = 1'b0;
      repeat (2) @(negedge clock);
      chk("rst_pin_release", 8'h00, {7'h0, rst_pin_oe});
      trap = 1'b1;
      repeat (2) @(negedge clock);
      chk("rst_pin_trap", 8'h01, {7'h0, rst_pin_oe});
      trap = 1'b0;
      clkr = 1'b1;
      repeat (2) @(negedge clock);
      chk("rst_pin_clk", 8'h01, {7'h0, rst_pin_oe});
      clkr = 1'b0;
      $display("test reset pin done");
   endtask : t_rstpin

   task tally_and_finish;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      t_reset;
      t_port4;
      t_video;
      t_inputs;
      t_ports;
      t_rstpin;
      tally_and_finish;
   end

   // the tests need well under 200 cycles
   initial
   begin
      #200us;
      fails++;
      tally_and_finish;
   end
endmodule : port_pin_function_mux_tb
